// >>> drain_source_fault_monitor.sv
// Drain-source overvoltage fault core with APB registers for four half-bridges.
// Assumes external comparators per bridge and gate commands from core-clock logic.
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/100ps
module drain_source_fault_monitor (
    // Clock, reset, enable
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    // APB slave
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    // Device enable pin
    input  wire logic        i_en,
    // Gate commands from the bridge control logic
    input  wire logic [3:0]  i_hs_on,
    input  wire logic [3:0]  i_ls_on,
    // Comparator pins, high when difference exceeds threshold
    input  wire logic [3:0]  i_hs_drain_cmp,
    input  wire logic [3:0]  i_hs_csense_cmp,
    input  wire logic [3:0]  i_ls_cmp,
    // Gate drives and analog settings
    output logic      [3:0]  o_hs_drive,
    output logic      [3:0]  o_ls_drive,
    output logic      [3:0]  o_static_discharge,
    output logic      [4:0]  o_static_discharge_current_setting,
    output logic      [11:0] o_hb_overvoltage_threshold_code,
    output logic      [3:0]  o_drain_sense_select,
    // Interrupt
    output logic             o_irq
);

    localparam int N = dsmon_pkg::NUM_HB;

    // ********************
    // Register state
    // ********************
    logic                              bridge_passive_select;
    logic [1:0]                        overvoltage_filter_time_code;
    logic [4:0]                        static_discharge_current_setting;
    logic [11:0]                       thr_code;
    logic [3:0]                        drain_sense_select;
    logic [11:0]                       blank_code;
    logic [N-1:0]                      drain_source_fault_status;
    logic                              global_overvoltage_error_flag;
    logic [dsmon_pkg::STATUS_W-1:0]    irq_mask;

    // ********************
    // Synchronisers
    // ********************
    logic        en_meta;
    logic        en_sync;
    logic [11:0] cmp_meta;
    logic [11:0] cmp_sync;

    // ********************
    // Internal signals
    // ********************
    logic                              active;
    logic [N-1:0]                      fault_hit;
    logic                              wr_en;
    logic                              rd_phase;
    logic [N-1:0]                      clr_status;
    logic                              clr_global;
    logic [dsmon_pkg::STATUS_W-1:0]    status_vec;
    logic [31:0]                       next_prdata;
    logic                              next_pslverr;

    // One monitor link per half-bridge
    hb_mon_if hb_if [N] ();

    // Decodes an address into a mapped flag
    function automatic logic is_mapped(input logic [7:0] a);
        return (a <= dsmon_pkg::OFS_LIVE_STATE) && (a[1:0] == 2'h0);
    endfunction

    // Enable pin passes two flops before any logic reads it
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
        end else if (i_ce) begin
            en_meta <= i_en;
            en_sync <= en_meta;
        end
    end

    // Comparator levels are asynchronous to the core clock
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cmp_meta <= '0;
            cmp_sync <= '0;
        end else if (i_ce) begin
            cmp_meta <= {i_ls_cmp, i_hs_csense_cmp, i_hs_drain_cmp};
            cmp_sync <= cmp_meta;
        end
    end

    // Passive select or a low enable pin idles every bridge
    assign active = en_sync & ~bridge_passive_select;

    // ********************
    // APB access
    // ********************
    // Access phase without pready: the answer is latched now
    assign rd_phase = i_psel & i_penable & ~o_pready;
    // A write lands on the edge that samples pready high
    assign wr_en    = i_psel & i_penable & o_pready & i_pwrite & ~o_pslverr;

    always_comb begin
        next_prdata = '0;
        unique case (i_paddr)
            dsmon_pkg::OFS_GENERAL_CONTROL_TWO: begin
                next_prdata[dsmon_pkg::POS_PASSIVE]                             = bridge_passive_select;
                next_prdata[dsmon_pkg::POS_FILT_CODE +: 2]                      = overvoltage_filter_time_code;
                next_prdata[dsmon_pkg::POS_ST_DCHG +: dsmon_pkg::ST_DCHG_W]     = static_discharge_current_setting;
            end
            dsmon_pkg::OFS_VDS_THRESHOLD_CONFIG: begin
                next_prdata[11:0]                             = thr_code;
                next_prdata[dsmon_pkg::POS_SENSE_SEL +: N]    = drain_sense_select;
            end
            dsmon_pkg::OFS_BLANK_CONFIG: begin
                next_prdata[11:0] = blank_code;
            end
            dsmon_pkg::OFS_FAULT_STATUS: begin
                next_prdata[dsmon_pkg::STATUS_W-1:0] = status_vec;
            end
            dsmon_pkg::OFS_IRQ_MASK: begin
                next_prdata[dsmon_pkg::STATUS_W-1:0] = irq_mask;
            end
            dsmon_pkg::OFS_LIVE_STATE: begin
                next_prdata[3:0] = o_hs_drive;
                next_prdata[7:4] = o_ls_drive;
                next_prdata[8]   = en_sync;
                next_prdata[9]   = active;
            end
            default: begin
                next_prdata = '0;
            end
        endcase
        next_pslverr = ~is_mapped(i_paddr);
    end

    // One wait state: data and error are registered on the same edge that raises pready
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_pready  <= 1'b0;
            o_prdata  <= '0;
            o_pslverr <= 1'b0;
        end else if (i_ce) begin
            if (rd_phase) begin
                o_pready  <= 1'b1;
                o_prdata  <= i_pwrite ? 32'h0000_0000 : next_prdata;
                o_pslverr <= next_pslverr;
            end else begin
                o_pready  <= 1'b0;
                o_pslverr <= 1'b0;
            end
        end
    end

    // ********************
    // Configuration registers
    // ********************
    // Passive select, filter code and discharge setting
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bridge_passive_select            <= 1'b0;
            overvoltage_filter_time_code     <= dsmon_pkg::RST_FILT_CODE;
            static_discharge_current_setting <= dsmon_pkg::RST_ST_DCHG;
        end else if (i_ce && wr_en && i_paddr == dsmon_pkg::OFS_GENERAL_CONTROL_TWO) begin
            bridge_passive_select            <= i_pwdata[dsmon_pkg::POS_PASSIVE];
            overvoltage_filter_time_code     <= i_pwdata[dsmon_pkg::POS_FILT_CODE +: 2];
            static_discharge_current_setting <= i_pwdata[dsmon_pkg::POS_ST_DCHG +: dsmon_pkg::ST_DCHG_W];
        end
    end

    // Three threshold bits per bridge, bridge 0 lowest
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            thr_code           <= {N{dsmon_pkg::RST_THR_CODE}};
            drain_sense_select <= '0;
        end else if (i_ce && wr_en && i_paddr == dsmon_pkg::OFS_VDS_THRESHOLD_CONFIG) begin
            thr_code           <= i_pwdata[11:0];
            drain_sense_select <= i_pwdata[dsmon_pkg::POS_SENSE_SEL +: N];
        end
    end

    // Three blank-time bits per bridge
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            blank_code <= {N{dsmon_pkg::RST_BLANK_CODE}};
        end else if (i_ce && wr_en && i_paddr == dsmon_pkg::OFS_BLANK_CONFIG) begin
            blank_code <= i_pwdata[11:0];
        end
    end

    // Mask has the layout of the status word
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            irq_mask <= '0;
        end else if (i_ce && wr_en && i_paddr == dsmon_pkg::OFS_IRQ_MASK) begin
            irq_mask <= i_pwdata[dsmon_pkg::STATUS_W-1:0];
        end
    end

    // ********************
    // Fault status, write one to clear, set wins
    // ********************
    assign clr_status = (wr_en && i_paddr == dsmon_pkg::OFS_FAULT_STATUS) ? i_pwdata[N-1:0] : '0;
    assign clr_global = wr_en && (i_paddr == dsmon_pkg::OFS_FAULT_STATUS) && i_pwdata[dsmon_pkg::POS_GLOBAL_FLAG];
    assign status_vec = {global_overvoltage_error_flag, 4'h0, drain_source_fault_status};

    // A fault in the clearing cycle keeps its bit set
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            drain_source_fault_status <= '0;
        end else if (i_ce) begin
            drain_source_fault_status <= fault_hit | (drain_source_fault_status & ~clr_status);
        end
    end

    // Global flag clears only through its own bit
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            global_overvoltage_error_flag <= 1'b0;
        end else if (i_ce) begin
            if (|fault_hit) begin
                global_overvoltage_error_flag <= 1'b1;
            end else if (clr_global) begin
                global_overvoltage_error_flag <= 1'b0;
            end
        end
    end

    // Level interrupt, one cycle behind the status
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_irq <= |(status_vec & irq_mask);
        end
    end

    // ********************
    // Per-bridge drive gating and monitor channels
    // ********************
    for (genvar g = 0; g < N; g++) begin : g_hb
        logic latched;

        // A fault in this cycle already blocks the next drive
        assign latched = drain_source_fault_status[g] | fault_hit[g];

        always_ff @(posedge i_clk) begin
            if (i_rst) begin
                o_hs_drive[g]         <= 1'b0;
                o_ls_drive[g]         <= 1'b0;
                o_static_discharge[g] <= 1'b0;
            end else if (i_ce) begin
                o_hs_drive[g]         <= i_hs_on[g] & active & ~latched;
                o_ls_drive[g]         <= i_ls_on[g] & active & ~latched;
                o_static_discharge[g] <= latched;
            end
        end

        assign hb_if[g].hs_drive   = o_hs_drive[g] & active;
        assign hb_if[g].ls_drive   = o_ls_drive[g] & active;
        assign hb_if[g].hs_over    = drain_sense_select[g] ? cmp_sync[4 + g] : cmp_sync[g];
        assign hb_if[g].ls_over    = cmp_sync[8 + g];
        assign hb_if[g].blank_code = blank_code[3*g +: 3];
        assign hb_if[g].filt_code  = overvoltage_filter_time_code;
        assign fault_hit[g]        = hb_if[g].fault;

        hb_fault_channel u_channel (
            .i_clk (i_clk),
            .i_rst (i_rst),
            .i_ce  (i_ce),
            .mon   (hb_if[g])
        );
    end

    // ********************
    // Analog settings out
    // ********************
    // Registered copies for the analog side
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_hb_overvoltage_threshold_code    <= {N{dsmon_pkg::RST_THR_CODE}};
            o_drain_sense_select               <= '0;
            o_static_discharge_current_setting <= dsmon_pkg::RST_ST_DCHG;
        end else if (i_ce) begin
            o_hb_overvoltage_threshold_code    <= thr_code;
            o_drain_sense_select               <= drain_sense_select;
            o_static_discharge_current_setting <= static_discharge_current_setting;
        end
    end

endmodule // drain_source_fault_monitor

// >>> dsmon_pkg.sv
// Constants, register map and timing for the drain-source fault monitor.
// Assumes a 50 MHz core clock and an APB register bus with 32-bit data.
package dsmon_pkg;

    // ********************
    // Sizes
    // ********************
    localparam int NUM_HB     = 4;
    localparam int CORE_MHZ   = 50;
    localparam int BLANK_W    = 10;
    localparam int FILT_W     = 8;

    // ********************
    // Register offsets (byte addresses)
    // ********************
    localparam logic [7:0] OFS_GENERAL_CONTROL_TWO = 8'h00;
    localparam logic [7:0] OFS_VDS_THRESHOLD_CONFIG = 8'h04;
    localparam logic [7:0] OFS_BLANK_CONFIG        = 8'h08;
    localparam logic [7:0] OFS_FAULT_STATUS        = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK            = 8'h10;
    localparam logic [7:0] OFS_LIVE_STATE          = 8'h14;

    // ********************
    // Field positions
    // ********************
    localparam int POS_PASSIVE      = 0;
    localparam int POS_FILT_CODE    = 1;
    localparam int POS_ST_DCHG      = 8;
    localparam int ST_DCHG_W        = 5;
    localparam int POS_SENSE_SEL    = 16;
    localparam int POS_GLOBAL_FLAG  = 8;
    localparam int STATUS_W         = 9;

    // ********************
    // Reset values
    // ********************
    localparam logic [1:0]  RST_FILT_CODE  = 2'h0;
    localparam logic [2:0]  RST_THR_CODE   = 3'h1;
    localparam logic [2:0]  RST_BLANK_CODE = 3'h4;
    localparam logic [4:0]  RST_ST_DCHG    = 5'h00;

    // ********************
    // Times in ns and derived cycle counts
    // ********************
    localparam int FILT_NS [4] = '{500, 1000, 2000, 3000};
    localparam int BLANK_NS [8] = '{625, 1000, 1250, 1500, 2000, 3000, 4000, 16000};

    // Least times: round up to whole cycles, never below one
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * CORE_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic logic [FILT_W-1:0] filt_cycles(input logic [1:0] code);
        return FILT_W'(ns_to_cyc(FILT_NS[code]));
    endfunction

    function automatic logic [BLANK_W-1:0] blank_cycles(input logic [2:0] code);
        return BLANK_W'(ns_to_cyc(BLANK_NS[code]));
    endfunction

endpackage

// >>> hb_mon_if.sv
// Per-half-bridge link between the fault core and one monitor channel.
// Assumes all signals are on the core clock.
`timescale 1ns/100ps
interface hb_mon_if;
    logic       hs_drive;
    logic       ls_drive;
    logic       hs_over;
    logic       ls_over;
    logic [2:0] blank_code;
    logic [1:0] filt_code;
    logic       fault;

    modport mon (
        input  hs_drive, ls_drive, hs_over, ls_over, blank_code, filt_code,
        output fault
    );
    modport core (
        output hs_drive, ls_drive, hs_over, ls_over, blank_code, filt_code,
        input  fault
    );
endinterface

// >>> hb_fault_channel.sv
// Blank and filter timing for one half-bridge.
// Assumes synchronised comparator levels and registered gate drives.
`timescale 1ns/100ps
module hb_fault_channel (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    input  wire logic i_ce,
    // Bridge link
    hb_mon_if.mon     mon
);

    logic                             hs_q;
    logic                             ls_q;
    logic                             new_act;
    logic [dsmon_pkg::BLANK_W-1:0]    blank_cnt;
    logic [dsmon_pkg::FILT_W-1:0]     filt_cnt;
    logic [dsmon_pkg::FILT_W-1:0]     filt_lim;
    logic                             over;
    logic                             fault;

    assign new_act  = (mon.hs_drive & ~hs_q) | (mon.ls_drive & ~ls_q);
    assign filt_lim = dsmon_pkg::filt_cycles(mon.filt_code);
    assign over     = ((mon.hs_drive & mon.hs_over) | (mon.ls_drive & mon.ls_over))
                      & (blank_cnt == '0) & ~new_act;
    assign mon.fault = fault;

    // ********************
    // Activation edges and blanking
    // ********************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            hs_q <= 1'b0;
            ls_q <= 1'b0;
        end else if (i_ce) begin
            hs_q <= mon.hs_drive;
            ls_q <= mon.ls_drive;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            blank_cnt <= '0;
        end else if (i_ce) begin
            if (new_act) begin
                blank_cnt <= dsmon_pkg::blank_cycles(mon.blank_code);
            end else if (blank_cnt != '0) begin
                blank_cnt <= blank_cnt - 1'b1;
            end
        end
    end

    // ********************
    // Filter: must stay over threshold longer than the filter time
    // ********************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            filt_cnt <= '0;
            fault    <= 1'b0;
        end else if (i_ce) begin
            fault <= 1'b0;
            if (!over) begin
                filt_cnt <= '0;
            end else if (filt_cnt == filt_lim) begin
                fault    <= 1'b1;
                filt_cnt <= '0;
            end else begin
                filt_cnt <= filt_cnt + 1'b1;
            end
        end
    end

endmodule // hb_fault_channel

// >>> drain_source_fault_monitor_properties.sv
// Concurrent checks on the top-level ports of the drain-source fault monitor.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/100ps
module drain_source_fault_monitor_properties (
    // Clock and reset
    input wire logic        i_clk,
    input wire logic        i_rst,
    // APB
    input wire logic        i_psel,
    input wire logic        i_penable,
    input wire logic        i_pwrite,
    input wire logic [7:0]  i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic        o_pready,
    input wire logic        o_pslverr,
    // Bridge side
    input wire logic [3:0]  i_hs_on,
    input wire logic [3:0]  o_hs_drive,
    input wire logic [3:0]  o_ls_drive,
    input wire logic [3:0]  o_static_discharge,
    input wire logic [4:0]  o_static_discharge_current_setting,
    input wire logic [11:0] o_hb_overvoltage_threshold_code,
    input wire logic [3:0]  o_drain_sense_select,
    input wire logic        o_irq
);
    // ********************
    // Helpers and properties
    // ********************
    localparam int MIN_TRIP = 57;
    logic [9:0] on_cnt;
    logic       acc;
    logic       wr_done;
    logic       mapped;
    assign acc     = i_psel && i_penable && !o_pready;
    assign wr_done = i_psel && i_penable && o_pready && i_pwrite;
    assign mapped  = (i_paddr <= 8'h14) && (i_paddr[1:0] == 2'h0);
    // Length of the latest on-time of bridge 0, held once it ends
    always_ff @(posedge i_clk) begin
        if (i_rst || $rose(o_hs_drive[0] | o_ls_drive[0])) begin
            on_cnt <= 10'h000;
        end else if ((o_hs_drive[0] | o_ls_drive[0]) && on_cnt != 10'h3ff) begin
            on_cnt <= on_cnt + 10'h001;
        end
    end
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_pready_pulse; o_pready |=> !o_pready; endproperty
    a_pready_pulse: assert property (p_pready_pulse) else $error("pready longer than one cycle");
    property p_pready_wait; acc |=> o_pready; endproperty
    a_pready_wait: assert property (p_pready_wait) else $error("pready late");
    property p_err_with_ready; o_pslverr |-> o_pready; endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("pslverr without pready");
    property p_unmapped; acc && !mapped |=> o_pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_mapped; acc && mapped |=> !o_pslverr; endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_drive_cmd; (o_hs_drive & ~$past(i_hs_on)) == 4'h0; endproperty
    a_drive_cmd: assert property (p_drive_cmd) else $error("drive without command");
    property p_thr_copy; wr_done && i_paddr == 8'h04 |=> ##1 o_hb_overvoltage_threshold_code ==
        $past(i_pwdata[11:0], 2) && o_drain_sense_select == $past(i_pwdata[19:16], 2); endproperty
    a_thr_copy: assert property (p_thr_copy) else $error("threshold or select not applied");
    property p_dchg_copy; wr_done && i_paddr == 8'h00 |=> ##1
        o_static_discharge_current_setting == $past(i_pwdata[12:8], 2); endproperty
    a_dchg_copy: assert property (p_dchg_copy) else $error("discharge setting not applied");
    property p_min_trip; $rose(o_static_discharge[0]) |-> on_cnt >= MIN_TRIP; endproperty
    a_min_trip: assert property (p_min_trip) else $error("fault before blank and filter");
    property p_reset_vals; $fell(i_rst) |-> o_hb_overvoltage_threshold_code == 12'h249 && !o_irq &&
        o_static_discharge == 4'h0; endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("wrong values after reset");
endmodule // drain_source_fault_monitor_properties

bind drain_source_fault_monitor drain_source_fault_monitor_properties drain_source_fault_monitor_properties_inst (.*);

// >>> hb_short_model.sv
// External MOSFETs and drain-source comparators of four half-bridges.
// Assumes registered gate drives; faults are injected by the bench.
`timescale 1ns/100ps
module hb_short_model (
    // Drives and sense routing
    input  wire logic [3:0] i_hs_drive,
    input  wire logic [3:0] i_ls_drive,
    input  wire logic [3:0] i_sel,
    // Injected faults; stray is a level on the unselected path
    input  wire logic [3:0] i_short_hs,
    input  wire logic [3:0] i_short_ls,
    input  wire logic [3:0] i_stray,
    // Comparator levels
    output logic      [3:0] o_drain_cmp,
    output logic      [3:0] o_csense_cmp,
    output logic      [3:0] o_ls_cmp
);
    // A shorted switch shows overvoltage only while it is driven on
    assign o_drain_cmp  = i_hs_drive & ((i_short_hs & ~i_sel) | (i_stray & i_sel));
    assign o_csense_cmp = i_hs_drive & ((i_short_hs & i_sel) | (i_stray & ~i_sel));
    assign o_ls_cmp     = i_ls_drive & i_short_ls;
endmodule // hb_short_model

// >>> tb_drain_source_fault_monitor.sv
// Self-checking bench for the drain-source fault monitor.
// Assumes the far-side model and the bound port checker.
`timescale 1ns/100ps
module tb_drain_source_fault_monitor;
    // ********************
    // Signals, model and tasks
    // ********************
    localparam int FILT_CYC [4] = '{25, 50, 100, 150};
    localparam int BLANK_CYC    = 100;
    logic        i_clk = 1'b0, i_rst = 1'b1, i_en = 1'b1, i_ce = 1'b1;
    logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0, o_pready, o_pslverr, o_irq;
    logic [7:0]  i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0, o_prdata;
    logic [3:0]  i_hs_on = 4'h0, i_ls_on = 4'h0, short_hs = 4'h0, short_ls = 4'h0, stray = 4'h0;
    logic [3:0]  o_hs_drive, o_ls_drive, o_static_discharge, o_drain_sense_select, d_cmp, c_cmp, l_cmp;
    logic [4:0]  o_static_discharge_current_setting;
    logic [11:0] o_hb_overvoltage_threshold_code;
    logic [32:0] exp_q [$];
    logic [32:0] e;
    int          error_cnt = 0;
    int          checks_done = 0;
    always #10 i_clk = ~i_clk;
    drain_source_fault_monitor drain_source_fault_monitor_inst (.*, .i_hs_drain_cmp(d_cmp),
        .i_hs_csense_cmp(c_cmp), .i_ls_cmp(l_cmp));
    hb_short_model hb_short_model_inst (.i_hs_drive(o_hs_drive), .i_ls_drive(o_ls_drive),
        .i_sel(o_drain_sense_select), .i_short_hs(short_hs), .i_short_ls(short_ls), .i_stray(stray),
        .o_drain_cmp(d_cmp), .o_csense_cmp(c_cmp), .o_ls_cmp(l_cmp));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Expected {error, read data} is queued; the watcher below compares it
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [32:0] x);
        int k;
        @(posedge i_clk);
        i_psel <= 1'b1;
        i_paddr <= a;
        i_pwrite <= w;
        i_pwdata <= d;
        exp_q.push_back(x);
        @(posedge i_clk);
        i_penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge i_clk);
            if (o_pready === 1'b1) break;
        end
        if (k == 20) begin
            error_cnt++;
            summarize();
        end
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic wait_drive(input int b, input logic hs, input logic lvl, output int cyc);
        for (cyc = 0; cyc < 400; cyc++) begin
            @(posedge i_clk);
            if ((hs ? o_hs_drive[b] : o_ls_drive[b]) === lvl) break;
        end
        if (cyc == 400) begin
            error_cnt++;
            summarize();
        end
    endtask
    always @(posedge i_clk) begin
        if (i_psel && i_penable && o_pready === 1'b1) begin
            e = exp_q.pop_front();
            check({31'h0, o_pslverr}, {31'h0, e[32]});
            if (!i_pwrite) check(o_prdata, e[31:0]);
        end
    end
    // ********************
    // Scenarios
    // ********************
    initial begin
        int f, c, r;
        r = $urandom(55);
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        apb(8'h00, 0, 0, 33'h0);
        apb(8'h04, 0, 0, 33'h249);
        apb(8'h08, 0, 0, 33'h924);
        apb(8'h0c, 0, 0, 33'h0);
        apb(8'h18, 0, 0, {1'b1, 32'h0});
        apb(8'h18, 1, 32'hffffffff, {1'b1, 32'h0});
        check(o_hb_overvoltage_threshold_code, 32'h249);
        $display("test reset done");
        for (f = 0; f < 8; f++) begin
            r = ($urandom() & 32'h000f0000) | {20'h0, f[2:0], f[2:0], f[2:0], f[2:0]};
            apb(8'h04, 1, r, 33'h0);
            apb(8'h04, 0, 0, {1'b0, r});
            check({o_drain_sense_select, o_hb_overvoltage_threshold_code}, {r[19:16], r[11:0]});
        end
        apb(8'h04, 1, 32'h000a0249, 33'h0);
        apb(8'h10, 1, 32'h1ff, 33'h0);
        $display("test codes done");
        for (f = 0; f < 4; f++) begin
            r = $urandom() & 32'h1f;
            apb(8'h00, 1, {19'h0, r[4:0], 5'h0, f[1:0], 1'b0}, 33'h0);
            repeat (2) @(posedge i_clk);
            check(o_static_discharge_current_setting, r);
            stray[f] <= 1'b1;
            i_hs_on[f] <= 1'b1;
            repeat (300) @(posedge i_clk);
            check(o_hs_drive[f], 1);
            stray[f] <= 1'b0;
            i_hs_on[f] <= 1'b0;
            repeat (4) @(posedge i_clk);
            short_hs[f] <= 1'b1;
            i_hs_on[f] <= 1'b1;
            wait_drive(f, 1, 1, c);
            wait_drive(f, 1, 0, c);
            check(c >= BLANK_CYC + FILT_CYC[f] && c <= BLANK_CYC + FILT_CYC[f] + 8, 1);
            apb(8'h0c, 0, 0, 33'h100 | (33'h1 << f));
            check({o_irq, o_static_discharge[f], o_hs_drive[f]}, 32'h6);
            short_hs[f] <= 1'b0;
            apb(8'h0c, 1, 32'h100 | (32'h1 << f), 33'h0);
            wait_drive(f, 1, 1, c);
            check(o_irq, 0);
            i_hs_on[f] <= 1'b0;
        end
        $display("test faults done");
        apb(8'h00, 1, 32'h0, 33'h0);
        apb(8'h10, 1, 32'h0, 33'h0);
        i_ls_on[2] <= 1'b1;
        repeat (120) @(posedge i_clk);
        repeat (3) begin
            short_ls[2] <= 1'b1;
            repeat (20) @(posedge i_clk);
            short_ls[2] <= 1'b0;
            repeat (3) @(posedge i_clk);
        end
        check(o_ls_drive[2], 1);
        short_ls[2] <= 1'b1;
        wait_drive(2, 0, 0, c);
        check(c <= 35, 1);
        apb(8'h0c, 0, 0, 33'h104);
        check(o_irq, 0);
        apb(8'h10, 1, 32'h1ff, 33'h0);
        repeat (2) @(posedge i_clk);
        check(o_irq, 1);
        short_ls[2] <= 1'b0;
        apb(8'h0c, 1, 32'h4, 33'h0);
        apb(8'h0c, 0, 0, 33'h100);
        apb(8'h0c, 1, 32'h100, 33'h0);
        repeat (3) @(posedge i_clk);
        check({o_irq, o_ls_drive[2]}, 32'h1);
        i_ls_on[2] <= 1'b0;
        $display("test filter done");
        apb(8'h00, 1, 32'h1, 33'h0);
        i_hs_on <= 4'hf;
        repeat (4) @(posedge i_clk);
        check(o_hs_drive, 0);
        apb(8'h00, 1, 32'h0, 33'h0);
        i_en <= 1'b0;
        repeat (6) @(posedge i_clk);
        check(o_hs_drive, 0);
        i_en <= 1'b1;
        repeat (6) @(posedge i_clk);
        check(o_hs_drive, 32'hf);
        i_ce <= 1'b0;
        i_en <= 1'b0;
        repeat (6) @(posedge i_clk);
        check(o_hs_drive, 32'hf);
        $display("test enable done");
        summarize();
    end
endmodule // tb_drain_source_fault_monitor
